//--- include/vcih_defines.svh
// field positions, reset values and fixed identifiers of the hypervisor control block
`ifndef VCIH_DEFINES_SVH
`define VCIH_DEFINES_SVH

`define VCIH_CNT_HI 31
`define VCIH_CNT_LO 27
`define VCIH_DEACTIVATE_WRITE_TRAP_BIT 14
`define VCIH_LOCAL_SYSTEM_ERROR_TRAP_BIT 13
`define VCIH_GROUP1_ACCESS_TRAP_BIT 12
`define VCIH_GROUP0_ACCESS_TRAP_BIT 11
`define VCIH_TC_BIT 10
`define VCIH_G1D_BIT 7
`define VCIH_G1E_BIT 6
`define VCIH_G0D_BIT 5
`define VCIH_G0E_BIT 4
`define VCIH_NP_BIT 3
`define VCIH_LRENP_BIT 2
`define VCIH_UIE_BIT 1
`define VCIH_EN_BIT 0
`define VCIH_RW_MASK 32'hf800_7cff
`define VCIH_RESET_VAL 32'h0000_0000
`define VCIH_SPURIOUS_ID 32'h0000_03ff
`define VCIH_LPI_BASE 32'h0000_2000
`define VCIH_ST_INACTIVE 2'h0
`define VCIH_ST_PENDING_BIT 0

`endif

//--- include/vcih_pkg.sv
// types shared by the hypervisor control block
package vcih_pkg;

  typedef enum logic [1:0] {
    VCIH_LVL_GUEST = 2'h0,
    VCIH_LVL_HYP = 2'h1,
    VCIH_LVL_MON = 2'h3
  } vcih_level_e;

  typedef enum logic [2:0] {
    VCIH_CLS_NONE = 3'h0,
    VCIH_CLS_GRP0 = 3'h1,
    VCIH_CLS_GRP1 = 3'h3,
    VCIH_CLS_COMMON = 3'h2,
    VCIH_CLS_DIR = 3'h6
  } vcih_class_e;

  typedef struct packed {
    logic valid;
    logic write;
    vcih_level_e level;
    logic [31:0] wdata;
  } vcih_sreg_req_s;

  typedef struct packed {
    logic done;
    logic trap_hyp;
    logic trap_mon;
    logic [31:0] rdata;
  } vcih_sreg_rsp_s;

  typedef struct packed {
    logic valid;
    logic write;
    vcih_class_e cls;
  } vcih_guest_acc_s;

  typedef struct packed {
    logic eoi_wr;
    logic dir_wr;
    logic id_valid;
    logic split_mode;
    logic lr_hit;
    logic ap_cleared;
    logic [31:0] intid;
  } vcih_deact_s;

  typedef struct packed {
    logic [1:0] state;
    logic hw;
    logic eoi;
  } vcih_entry_s;

endpackage : vcih_pkg

//--- logic/vcih_ctrl.sv
// hypervisor control register and maintenance logic of the virtual cpu interface
// What this block does
// (R1) count unmatched guest end-of-interrupt writes, id below 8192, split mode off
// (R2) count unmatched guest deactivate writes, id below 8192, split mode on
// (R3) end-of-interrupt clearing no active priority may count or not
// (R4) reset clears every implemented field including counter
// (R5) deactivate trap bit 14 diverts guest deactivate writes to hypervisor
// (R6) without deactivate trap support bit 14 reads zero
// (R7) bit 13 traps local system errors; reads zero without support
// (R8) bit 12 traps every guest group 1 register access
// (R9) bit 11 traps every guest group 0 register access
// (R10) bit 10 traps guest accesses to common registers
// (R11) bit 7 raises maintenance while guest group 1 disabled
// (R12) bit 6 raises maintenance while guest group 1 enabled
// (R13) bit 5 raises maintenance while guest group 0 disabled
// (R14) bit 4 raises maintenance while guest group 0 enabled
// (R15) bit 3 raises maintenance while no entry pending
// (R16) bit 2 raises maintenance while counter nonzero
// (R17) bit 1 raises maintenance while at most one entry valid
// (R18) enable low blocks maintenance and virtual interrupts
// (R19) enable low makes guest acknowledge reads return spurious id
// (R20) system register enables low trap hypervisor or monitor accesses
// (R21) without hypervisor level monitor reads zero, writes ignored
// (R22) 32-bit register, reserved bits read zero
// (R23) entry state 00 inactive, 01 pending, 10 active, 11 both
// (R24) entry empty when inactive and hardware or no notify
// (R25) maintenance output is gated OR of enabled conditions
`timescale 1ns/1ps
`include "vcih_defines.svh"
module vcih_ctrl #(
  parameter int NUM_LR = 16,
  parameter bit DEACTIVATE_WRITE_TRAP_SUPPORT = 1'b1,
  parameter bit SEI_SUPPORT = 1'b1,
  parameter bit HYP_IMPL = 1'b1,
  parameter bit NOAP_COUNTS = 1'b1
) (
  input wire logic mclk, // processor clock
  input wire logic reset_n, // async reset, active low
  input wire vcih_pkg::vcih_sreg_req_s sreg_req, // register move request
  output vcih_pkg::vcih_sreg_rsp_s sreg_rsp, // register move answer
  input wire logic hyp_sre, // hypervisor sysreg interface enable
  input wire logic mon_sre, // monitor sysreg interface enable
  input wire vcih_pkg::vcih_guest_acc_s guest_acc, // guest interface access
  output logic guest_trap, // access trapped to hypervisor
  input wire vcih_pkg::vcih_deact_s deact, // guest deactivation event
  input wire vcih_pkg::vcih_entry_s entries [NUM_LR], // list entries
  input wire logic guest_group0_signal_enable, // guest group 0 enable
  input wire logic guest_group1_signal_enable, // guest group 1 enable
  input wire logic local_sei, // local system error interrupt
  output logic sei_trap_hyp, // error taken at hypervisor
  output logic sei_to_guest, // error taken at guest
  input wire logic virq_in, // virtual interrupt from prioritizer
  output logic virq_out, // virtual interrupt to guest
  input wire logic ack_rd, // guest acknowledge read
  input wire logic [31:0] ack_id, // id the prioritizer offers
  output logic ack_valid, // acknowledge answer strobe
  output logic [31:0] ack_data, // acknowledged id
  output logic maint_irq // maintenance interrupt
);
  import vcih_pkg::*;

  localparam logic [31:0] DEACTIVATE_WRITE_TRAP_M = 32'h0000_4000;
  localparam logic [31:0] LOCAL_SYSTEM_ERROR_TRAP_M = 32'h0000_2000;
  // optional bits fall out of the writable mask, so they stay zero
  // (R6) unsupported bits masked
  localparam logic [31:0] IMPL_MASK = `VCIH_RW_MASK
    & ~(DEACTIVATE_WRITE_TRAP_SUPPORT ? 32'h0000_0000 : DEACTIVATE_WRITE_TRAP_M)
    & ~(SEI_SUPPORT ? 32'h0000_0000 : LOCAL_SYSTEM_ERROR_TRAP_M);

  logic [31:0] hcr_q, hcr_d;
  vcih_sreg_rsp_s rsp_q, rsp_d;
  logic trap_q, trap_d;
  logic sei_h_q, sei_h_d, sei_g_q, sei_g_d;
  logic virq_q, virq_d, maint_q, maint_d;
  logic ackv_q, ackv_d;
  logic [31:0] ackd_q, ackd_d;
  logic none_pending, few_valid, acc_trap;
  logic cnt_inc, wr_ok, rd_ok, en;
  logic [7:0] cause;

  assign en = hcr_q[`VCIH_EN_BIT];

  vcih_list_scan #(
    .NUM_LR(NUM_LR)
  ) u_scan (
    .entries(entries),
    .none_pending(none_pending),
    .few_valid(few_valid)
  );

  vcih_trap_decode u_trap (
    .acc(guest_acc),
    .deactivate_write_trap(hcr_q[`VCIH_DEACTIVATE_WRITE_TRAP_BIT]),
    .group0_access_trap(hcr_q[`VCIH_GROUP0_ACCESS_TRAP_BIT]),
    .group1_access_trap(hcr_q[`VCIH_GROUP1_ACCESS_TRAP_BIT]),
    .tc(hcr_q[`VCIH_TC_BIT]),
    .trap(acc_trap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register access and counter

  always_comb begin
    rsp_d = '0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    if (sreg_req.valid) begin
      rsp_d.done = 1'b1;
      // (R20) sysreg enable traps
      if (sreg_req.level == VCIH_LVL_HYP && !hyp_sre) begin
        rsp_d.trap_hyp = 1'b1;
      end else if (sreg_req.level == VCIH_LVL_MON && !mon_sre) begin
        rsp_d.trap_mon = 1'b1;
      // (R21) no hypervisor level: read zero, ignore writes
      end else if (sreg_req.level == VCIH_LVL_MON && !HYP_IMPL) begin
        rsp_d.rdata = 32'h0000_0000;
      end else if (sreg_req.level != VCIH_LVL_GUEST) begin
        wr_ok = sreg_req.write;
        rd_ok = !sreg_req.write;
      end
      // (R22) reserved bits never stored, so read zero
      if (rd_ok) begin
        rsp_d.rdata = hcr_q & IMPL_MASK;
      end
    end
  end

  always_comb begin
    // (R1) unmatched end-of-interrupt, split mode off
    // (R2) unmatched deactivate write, split mode on
    // (R3) optional count when no active priority cleared
    cnt_inc = deact.id_valid && (deact.intid < `VCIH_LPI_BASE) && !deact.lr_hit
      && ((deact.eoi_wr && !deact.split_mode && (deact.ap_cleared || NOAP_COUNTS))
      || (deact.dir_wr && deact.split_mode));
    hcr_d = hcr_q;
    if (wr_ok) begin
      hcr_d = sreg_req.wdata & IMPL_MASK;
    end
    // an event in the write cycle is counted on top of the written value
    if (cnt_inc) begin
      hcr_d[`VCIH_CNT_HI:`VCIH_CNT_LO] = hcr_d[`VCIH_CNT_HI:`VCIH_CNT_LO] + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // traps, maintenance and guest signalling

  always_comb begin
    trap_d = acc_trap;
    // (R7) local system error routing
    sei_h_d = local_sei && hcr_q[`VCIH_LOCAL_SYSTEM_ERROR_TRAP_BIT];
    sei_g_d = local_sei && !hcr_q[`VCIH_LOCAL_SYSTEM_ERROR_TRAP_BIT];
    // (R11) group 1 disabled
    cause[7] = hcr_q[`VCIH_G1D_BIT] && !guest_group1_signal_enable;
    // (R12) group 1 enabled
    cause[6] = hcr_q[`VCIH_G1E_BIT] && guest_group1_signal_enable;
    // (R13) group 0 disabled
    cause[5] = hcr_q[`VCIH_G0D_BIT] && !guest_group0_signal_enable;
    // (R14) group 0 enabled
    cause[4] = hcr_q[`VCIH_G0E_BIT] && guest_group0_signal_enable;
    // (R15) nothing pending
    cause[3] = hcr_q[`VCIH_NP_BIT] && none_pending;
    // (R16) counter nonzero
    cause[2] = hcr_q[`VCIH_LRENP_BIT] && (hcr_q[`VCIH_CNT_HI:`VCIH_CNT_LO] != 5'h00);
    // (R17) underflow
    cause[1] = hcr_q[`VCIH_UIE_BIT] && few_valid;
    cause[0] = 1'b0;
    // (R25) gated OR, one cycle behind its causes
    // (R18) global enable gates both outputs
    maint_d = en && (|cause);
    virq_d = en && virq_in;
    ackv_d = ack_rd;
    ackd_d = ackd_q;
    if (ack_rd) begin
      // (R19) spurious id while disabled
      ackd_d = en ? ack_id : `VCIH_SPURIOUS_ID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // (R4) architectural reset to zero
      hcr_q <= `VCIH_RESET_VAL;
      rsp_q <= '0;
      trap_q <= 1'b0;
      sei_h_q <= 1'b0;
      sei_g_q <= 1'b0;
      maint_q <= 1'b0;
      virq_q <= 1'b0;
      ackv_q <= 1'b0;
      ackd_q <= 32'h0000_0000;
    end else begin
      hcr_q <= hcr_d;
      rsp_q <= rsp_d;
      trap_q <= trap_d;
      sei_h_q <= sei_h_d;
      sei_g_q <= sei_g_d;
      maint_q <= maint_d;
      virq_q <= virq_d;
      ackv_q <= ackv_d;
      ackd_q <= ackd_d;
    end
  end

  assign sreg_rsp = rsp_q;
  assign guest_trap = trap_q;
  assign sei_trap_hyp = sei_h_q;
  assign sei_to_guest = sei_g_q;
  assign maint_irq = maint_q;
  assign virq_out = virq_q;
  assign ack_valid = ackv_q;
  assign ack_data = ackd_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_eoi_count: assert property ( // (R1)
    @(posedge mclk) disable iff (!reset_n)
    (deact.eoi_wr && !deact.dir_wr && deact.id_valid && !deact.split_mode && !deact.lr_hit
      && deact.ap_cleared && deact.intid < 32'h0000_2000 && !wr_ok)
    |=> hcr_q[31:27] == $past(hcr_q[31:27]) + 5'h01)
    else $error("counter missed an unmatched end of interrupt");

  a_dir_count: assert property ( // (R2)
    @(posedge mclk) disable iff (!reset_n)
    (!deact.eoi_wr && deact.dir_wr && deact.id_valid && deact.split_mode && !deact.lr_hit
      && deact.intid < 32'h0000_2000 && !wr_ok)
    |=> hcr_q[31:27] == $past(hcr_q[31:27]) + 5'h01)
    else $error("counter missed an unmatched deactivate");

  a_rsvd_zero: assert property ( // (R22)
    @(posedge mclk) disable iff (!reset_n)
    rsp_q.done |-> (rsp_q.rdata & 32'h07ff_8300) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  a_dir_trap: assert property ( // (R5)
    @(posedge mclk) disable iff (!reset_n)
    (guest_acc.valid && guest_acc.write && guest_acc.cls == VCIH_CLS_DIR && hcr_q[14])
    |=> guest_trap)
    else $error("deactivate write not trapped");

  a_grp1_trap: assert property ( // (R8)
    @(posedge mclk) disable iff (!reset_n)
    (guest_acc.valid && guest_acc.cls == VCIH_CLS_GRP1)
    |=> guest_trap == $past(hcr_q[12]))
    else $error("group 1 trap wrong");

  a_disabled_quiet: assert property ( // (R18)
    @(posedge mclk) disable iff (!reset_n)
    !en |=> !maint_irq && !virq_out)
    else $error("signal while interface disabled");

  a_spurious_ack: assert property ( // (R19)
    @(posedge mclk) disable iff (!reset_n)
    (ack_rd && !en) |=> ack_valid && ack_data == 32'h0000_03ff)
    else $error("acknowledge not spurious while disabled");

  a_count_maint: assert property ( // (R16)
    @(posedge mclk) disable iff (!reset_n)
    (en && hcr_q[2] && hcr_q[31:27] != 5'h00) |=> maint_irq)
    else $error("nonzero counter raised no maintenance");

  a_sre_trap: assert property ( // (R20)
    @(posedge mclk) disable iff (!reset_n)
    (sreg_req.valid && sreg_req.level == VCIH_LVL_HYP && !hyp_sre)
    |=> sreg_rsp.trap_hyp && hcr_q[26:0] == $past(hcr_q[26:0]))
    else $error("disabled sysreg access not trapped");

  a_grp0_trap: assert property ( // (R9)
    @(posedge mclk) disable iff (!reset_n)
    (guest_acc.valid && guest_acc.cls == VCIH_CLS_GRP0)
    |=> guest_trap == $past(hcr_q[11]))
    else $error("group 0 trap wrong");

  a_common_trap: assert property ( // (R10)
    @(posedge mclk) disable iff (!reset_n)
    (guest_acc.valid && guest_acc.cls == VCIH_CLS_COMMON)
    |=> guest_trap == $past(hcr_q[10]))
    else $error("common register trap wrong");

  a_sei_route: assert property ( // (R7)
    @(posedge mclk) disable iff (!reset_n)
    (local_sei && hcr_q[13]) |=> sei_trap_hyp && !sei_to_guest)
    else $error("local system error not trapped");

  a_opt_bits_zero: assert property ( // (R6)
    @(posedge mclk) disable iff (!reset_n)
    rsp_q.done |-> (DEACTIVATE_WRITE_TRAP_SUPPORT || !rsp_q.rdata[14]) && (SEI_SUPPORT || !rsp_q.rdata[13]))
    else $error("unsupported trap bit reads nonzero");

  a_mon_read_zero: assert property ( // (R21)
    @(posedge mclk) disable iff (!reset_n)
    (sreg_req.valid && sreg_req.level == VCIH_LVL_MON && mon_sre && !HYP_IMPL)
    |=> sreg_rsp.rdata == 32'h0000_0000 && hcr_q[26:0] == $past(hcr_q[26:0]))
    else $error("monitor access without hypervisor level not ignored");

  a_grp1_off_maint: assert property ( // (R11)
    @(posedge mclk) disable iff (!reset_n)
    (en && hcr_q[7] && !guest_group1_signal_enable) |=> maint_irq)
    else $error("group 1 disabled raised no maintenance");

  a_no_pend_maint: assert property ( // (R15)
    @(posedge mclk) disable iff (!reset_n)
    (en && hcr_q[3] && none_pending) |=> maint_irq)
    else $error("no pending entry raised no maintenance");

  a_underflow_maint: assert property ( // (R17)
    @(posedge mclk) disable iff (!reset_n)
    (en && hcr_q[1] && few_valid) |=> maint_irq)
    else $error("underflow raised no maintenance");

  a_no_enable_quiet: assert property ( // (R25)
    @(posedge mclk) disable iff (!reset_n)
    (hcr_q[7:1] == 7'h00) |=> !maint_irq)
    else $error("maintenance without any enabled condition");

endmodule : vcih_ctrl

//--- logic/vcih_list_scan.sv
// summary of list entries: any pending, at most one valid
`timescale 1ns/1ps
`include "vcih_defines.svh"
module vcih_list_scan #(
  parameter int NUM_LR = 16
) (
  input wire vcih_pkg::vcih_entry_s entries [NUM_LR], // list entry state
  output logic none_pending, // no entry pending
  output logic few_valid // zero or one valid entry
);
  import vcih_pkg::*;

  // (R24) empty entry test
  function automatic logic entry_valid(input vcih_entry_s e);
    entry_valid = !((e.state == `VCIH_ST_INACTIVE) && (e.hw || !e.eoi));
  endfunction : entry_valid

  always_comb begin
    int nvalid;
    nvalid = 0;
    none_pending = 1'b1;
    for (int i = 0; i < NUM_LR; i++) begin
      // (R23) pending is state 01 or 11
      if (entries[i].state[`VCIH_ST_PENDING_BIT]) begin
        none_pending = 1'b0;
      end
      if (entry_valid(entries[i])) begin
        nvalid = nvalid + 1;
      end
    end
    few_valid = (nvalid <= 1);
  end

endmodule : vcih_list_scan

//--- logic/vcih_trap_decode.sv
// decides whether a guest access to an interface register goes to the hypervisor
`timescale 1ns/1ps
module vcih_trap_decode (
  input wire vcih_pkg::vcih_guest_acc_s acc, // guest access
  input wire logic deactivate_write_trap, // deactivate write trap
  input wire logic group0_access_trap, // group 0 trap
  input wire logic group1_access_trap, // group 1 trap
  input wire logic tc, // common register trap
  output logic trap // access diverted
);
  import vcih_pkg::*;

  always_comb begin
    trap = 1'b0;
    if (acc.valid) begin
      case (acc.cls)
        // (R9) group 0 access trap
        VCIH_CLS_GRP0: trap = group0_access_trap;
        // (R8) group 1 access trap
        VCIH_CLS_GRP1: trap = group1_access_trap;
        // (R10) common register trap
        VCIH_CLS_COMMON: trap = tc;
        // (R5) deactivate write trap, also common
        VCIH_CLS_DIR: trap = tc | (acc.write & deactivate_write_trap);
        default: trap = 1'b0;
      endcase
    end
  end

endmodule : vcih_trap_decode

//--- tb/vcih_ctrl_bench.sv
// self-checking bench for the hypervisor control register block
`timescale 1ns/1ps
module vcih_ctrl_bench;
  import vcih_pkg::*;
  localparam int NLR = 16;
  localparam logic [31:0] MASK = 32'hf800_7cff;
  // the reduced build has no deactivate or system error trap bits
  localparam logic [31:0] OPT_OFF = 32'hffff_9fff;
  logic mclk, reset_n, hyp_sre, mon_sre, g0_en, g1_en, local_sei, virq_in, ack_rd;
  logic guest_trap, sei_trap_hyp, sei_to_guest, virq_out, ack_valid, maint_irq;
  logic [31:0] ack_id, ack_data, shadow, rd, rv, wd;
  logic [4:0] cnt;
  logic inc, inc_b, guest_trap_b, sei_trap_hyp_b;
  logic [31:0] rd_b;
  vcih_sreg_req_s sreg_req;
  vcih_sreg_rsp_s sreg_rsp;
  vcih_sreg_rsp_s sreg_rsp_b;
  vcih_guest_acc_s guest_acc;
  vcih_deact_s deact;
  vcih_entry_s entries [NLR];
  vcih_class_e cls_tab [5] = '{VCIH_CLS_NONE, VCIH_CLS_GRP0, VCIH_CLS_GRP1, VCIH_CLS_COMMON,
                               VCIH_CLS_DIR};
  int error_cnt, total_checks;
  integer seed = 71161;

  vcih_ctrl #(.NUM_LR(NLR)) dut (.mclk(mclk), .reset_n(reset_n), .sreg_req(sreg_req),
    .sreg_rsp(sreg_rsp), .hyp_sre(hyp_sre), .mon_sre(mon_sre), .guest_acc(guest_acc),
    .guest_trap(guest_trap), .deact(deact), .entries(entries),
    .guest_group0_signal_enable(g0_en), .guest_group1_signal_enable(g1_en),
    .local_sei(local_sei), .sei_trap_hyp(sei_trap_hyp), .sei_to_guest(sei_to_guest),
    .virq_in(virq_in), .virq_out(virq_out), .ack_rd(ack_rd), .ack_id(ack_id),
    .ack_valid(ack_valid), .ack_data(ack_data), .maint_irq(maint_irq));

  // reduced build: no optional traps, no hypervisor level, no count without priority clear
  vcih_ctrl #(.NUM_LR(NLR), .DEACTIVATE_WRITE_TRAP_SUPPORT(1'b0), .SEI_SUPPORT(1'b0), .HYP_IMPL(1'b0),
    .NOAP_COUNTS(1'b0)) dut_b (.mclk(mclk), .reset_n(reset_n), .sreg_req(sreg_req),
    .sreg_rsp(sreg_rsp_b), .hyp_sre(hyp_sre), .mon_sre(mon_sre), .guest_acc(guest_acc),
    .guest_trap(guest_trap_b), .deact(deact), .entries(entries),
    .guest_group0_signal_enable(g0_en), .guest_group1_signal_enable(g1_en),
    .local_sei(local_sei), .sei_trap_hyp(sei_trap_hyp_b), .sei_to_guest(),
    .virq_in(virq_in), .virq_out(), .ack_rd(ack_rd), .ack_id(ack_id),
    .ack_valid(), .ack_data(), .maint_irq());

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // one register move; answer is settled when the task returns
  task sreg(input vcih_level_e lvl, input logic wr, input logic [31:0] d);
    @(posedge mclk);
    sreg_req <= '{valid: 1'b1, write: wr, level: lvl, wdata: d};
    @(posedge mclk);
    sreg_req.valid <= 1'b0;
    #1;
    chk_bit(sreg_rsp.done, 1'b1, "done");
    chk_bit(sreg_rsp_b.done, 1'b1, "reduced done");
  endtask : sreg

  task hyp_rd;
    sreg(VCIH_LVL_HYP, 1'b0, 32'h0);
    rd = sreg_rsp.rdata;
    rd_b = sreg_rsp_b.rdata;
  endtask : hyp_rd

  task hyp_wr(input logic [31:0] d);
    sreg(VCIH_LVL_HYP, 1'b1, d);
    shadow = d & MASK;
  endtask : hyp_wr

  task guest(input vcih_class_e c, input logic wr, input logic exp, input logic exp_b);
    @(posedge mclk);
    guest_acc <= '{valid: 1'b1, write: wr, cls: c};
    @(posedge mclk);
    guest_acc.valid <= 1'b0;
    #1;
    chk_bit(guest_trap, exp, "guest trap");
    chk_bit(guest_trap_b, exp_b, "reduced guest trap");
  endtask : guest

  task event_send(input vcih_deact_s ev);
    @(posedge mclk);
    deact <= ev;
    @(posedge mclk);
    deact <= '0;
  endtask : event_send

  // maintenance level expected from register image and list state
  function automatic logic exp_maint(input logic [31:0] r);
    logic np;
    int nv;
    np = 1'b1;
    nv = 0;
    for (int i = 0; i < NLR; i++) begin
      if (entries[i].state[0]) np = 1'b0;
      if (!(entries[i].state == 2'h0 && (entries[i].hw || !entries[i].eoi))) nv++;
    end
    return r[0] & ((r[7] & !g1_en) | (r[6] & g1_en) | (r[5] & !g0_en) | (r[4] & g0_en)
                   | (r[3] & np) | (r[2] & (r[31:27] != 5'h0)) | (r[1] & (nv <= 1)));
  endfunction : exp_maint

  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end

  initial begin
    {reset_n, g0_en, g1_en, local_sei, virq_in, ack_rd, ack_id} = '0;
    {hyp_sre, mon_sre} = 2'b11;
    sreg_req = '0;
    guest_acc = '0;
    deact = '0;
    for (int i = 0; i < NLR; i++) entries[i] = '0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    hyp_rd;
    chk_val(rd, 32'h0, "reset value");
    chk_val(rd_b, 32'h0, "reduced reset value");
    chk_bit(maint_irq, 1'b0, "maint after reset");
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hffff_ffff : $random(seed);
      hyp_wr(wd);
      hyp_rd;
      chk_val(rd, wd & MASK, "readback");
      chk_val(rd_b, wd & MASK & OPT_OFF, "reduced readback");
    end
    @(posedge mclk);
    hyp_sre <= 1'b0;
    sreg(VCIH_LVL_HYP, 1'b1, 32'h0);
    chk_bit(sreg_rsp.trap_hyp, 1'b1, "hyp trap");
    hyp_sre <= 1'b1;
    mon_sre <= 1'b0;
    sreg(VCIH_LVL_MON, 1'b1, 32'h0);
    chk_bit(sreg_rsp.trap_mon, 1'b1, "mon trap");
    mon_sre <= 1'b1;
    sreg(VCIH_LVL_GUEST, 1'b1, 32'h0);
    sreg(VCIH_LVL_MON, 1'b0, 32'h0);
    chk_val(sreg_rsp.rdata, shadow, "unchanged");
    chk_val(sreg_rsp_b.rdata, 32'h0, "reduced monitor read");
    sreg(VCIH_LVL_MON, 1'b1, 32'h0000_0001);
    hyp_rd;
    chk_val(rd, 32'h0000_0001, "monitor write");
    chk_val(rd_b, shadow & OPT_OFF, "reduced monitor write");
    local_sei <= 1'b1;
    for (int it = 0; it < 6; it++) begin
      hyp_wr((it == 0) ? 32'h0000_6000 : ($random(seed) & 32'h0000_7c00));
      for (int c = 0; c < 10; c++) begin
        case (cls_tab[c/2])
          VCIH_CLS_GRP0: inc = shadow[11];
          VCIH_CLS_GRP1: inc = shadow[12];
          VCIH_CLS_COMMON: inc = shadow[10];
          VCIH_CLS_DIR: inc = shadow[10] | (shadow[14] & c[0]);
          default: inc = 1'b0;
        endcase
        // without the deactivate trap only the common trap diverts
        inc_b = (cls_tab[c/2] == VCIH_CLS_DIR) ? shadow[10] : inc;
        guest(cls_tab[c/2], c[0], inc, inc_b);
      end
      chk_bit(sei_trap_hyp, shadow[13], "sei hyp");
      chk_bit(sei_to_guest, !shadow[13], "sei guest");
      chk_bit(sei_trap_hyp_b, 1'b0, "reduced sei hyp");
    end
    for (int it = 0; it < 24; it++) begin
      for (int i = 0; i < NLR; i++) begin
        rv = (it < 2) ? 32'h0 : $random(seed);
        entries[i] <= '{state: rv[1:0] & {2{rv[2] & rv[3]}}, hw: rv[4],
                        eoi: rv[5] & rv[6] & rv[7]};
      end
      rv = $random(seed);
      {g0_en, g1_en, virq_in} <= rv[2:0];
      hyp_wr((it == 0) ? 32'hffff_fffe : $random(seed));
      repeat (2) @(posedge mclk);
      #1;
      inc = exp_maint(shadow);
      chk_bit(maint_irq, inc, "maint");
      chk_bit(virq_out, virq_in & shadow[0], "virq");
      @(posedge mclk);
      ack_rd <= 1'b1;
      ack_id <= $random(seed) & 32'h0000_1fff;
      @(posedge mclk);
      ack_rd <= 1'b0;
      #1;
      chk_bit(ack_valid, 1'b1, "ack strobe");
      chk_val(ack_data, shadow[0] ? ack_id : 32'h0000_03ff, "ack id");
    end
    for (int i = 0; i < NLR; i++) entries[i] <= '{state: 2'h1, hw: 1'b0, eoi: 1'b1};
    hyp_wr(32'hf000_0005);
    cnt = 5'd30;
    for (int it = 0; it < 40; it++) begin
      rv = $random(seed);
      wd = (it < 2) ? 32'h0000_1fff + it : rv[29:16];
      inc = rv[0] & (wd < 32'h0000_2000) & !rv[3] & (rv[1] ? rv[2] : !rv[2]);
      event_send('{eoi_wr: !rv[1], dir_wr: rv[1], id_valid: rv[0], split_mode: rv[2],
                   lr_hit: rv[3], ap_cleared: 1'b1, intid: wd});
      cnt = cnt + {4'h0, inc};
      hyp_rd;
      chk_val({27'h0, rd[31:27]}, {27'h0, cnt}, "counter");
      chk_val({27'h0, rd_b[31:27]}, {27'h0, cnt}, "reduced counter");
      chk_bit(maint_irq, cnt != 5'h0, "missing entry maint");
    end
    // either outcome accepted, in the counting and the non-counting build
    event_send('{eoi_wr: 1'b1, dir_wr: 1'b0, id_valid: 1'b1, split_mode: 1'b0,
                 lr_hit: 1'b0, ap_cleared: 1'b0, intid: 32'h0000_0005});
    hyp_rd;
    chk_bit((rd[31:27] === cnt) || (rd[31:27] === cnt + 5'd1), 1'b1, "no clear count");
    inc = (rd_b[31:27] === cnt) || (rd_b[31:27] === cnt + 5'd1);
    chk_bit(inc, 1'b1, "reduced no clear count");
    // reset in mid-run clears counter and every field
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    hyp_rd;
    chk_val(rd, 32'h0, "mid-run reset value");
    chk_val(rd_b, 32'h0, "reduced mid-run reset value");
    chk_bit(maint_irq, 1'b0, "maint after mid-run reset");
    complete_run;
  end
endmodule : vcih_ctrl_bench
